// ==== design/sadc_core.sv ====
// Summary of operation
// - Conversion timed by internal clock, about 6.4us
// - Select and read/convert low 40ns start
// - Start ignored while conversion runs
// - Busy low throughout conversion
// - Select low: read/convert fall starts conversion
// - Busy rises after result latched
// - Read/convert low keeps data lines floating
// - Select fall with read/convert low pulls busy low
// - Select low again reads the result
// - Result two's complement, word or bytes
// - Byte low: MSB byte on upper lines
// - Byte high: LSB byte on upper lines
// - Code wraps ones to zeros at zero
// - Select and read/convert combined by OR
// - SAR cleared, bits decided MSB first
`timescale 1ns/1ps
`default_nettype none
`include "sadc_params.svh"
module sadc_core
  import sadc_pkg::*;
#(
  parameter int W         = `SADC_WIDTH,
  parameter int START_CYC = `SADC_START_CYC,
  parameter int STEP_CYC  = `SADC_CONV_CYC / `SADC_WIDTH
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                select_n,
  input  wire logic                read_conv,
  input  wire logic                byte_swap,
  input  wire sadc_pkg::sadc_word_t analog_sample,
  output logic                     busy_n,
  output logic                     hold,
  output logic               [7:0] upper_data_lines,
  output logic               [7:0] lower_data_lines,
  output logic                     data_oe
);
  import sadc_pkg::*;

  localparam int SCW = $clog2(START_CYC + 1);

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [2:0] pin_s;
  logic       cs_s;
  logic       rc_s;
  logic       byte_s;

  sadc_sync #(
    .W (3)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({select_n, read_conv, byte_swap}),
    .q     (pin_s)
  );

  assign cs_s   = pin_s[2];
  assign rc_s   = pin_s[1];
  assign byte_s = pin_s[0];

  // ****************************************
  // Start qualification
  // ****************************************
  // Internal OR of the two controls; low means start request
  logic           start_lvl;
  logic           done_q;
  logic [SCW-1:0] low_cnt;
  logic           armed;
  logic [SCW-1:0] next_low_cnt;
  logic           next_armed;
  logic           start_pulse;
  logic           conv_active;

  assign start_lvl = !(cs_s | rc_s);

  always_comb begin
    next_low_cnt = low_cnt;
    next_armed   = armed;
    start_pulse  = 1'b0;
    if (!start_lvl) begin
      next_low_cnt = '0;
      next_armed   = 1'b1;
    end else if (low_cnt < SCW'(START_CYC)) begin
      next_low_cnt = low_cnt + 1'b1;
    end
    // One start per falling edge, held for the minimum width
    if (start_lvl && armed && (low_cnt + 1'b1 >= SCW'(START_CYC)) && !conv_active) begin
      start_pulse = 1'b1;
      next_armed  = 1'b0;
    end
    // A low level still present when busy rises starts again, as the pins do
    if (start_lvl && !armed && done_q && !conv_active) begin
      start_pulse = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt  <= '0;
      armed    <= 1'b1;
    end else begin
      low_cnt  <= next_low_cnt;
      armed    <= next_armed;
    end
  end

  // ****************************************
  // Conversion control
  // ****************************************
  sadc_state_e    state;
  sadc_state_e    next_state;
  sadc_word_t     sample_q;
  sadc_word_t     next_sample;
  sadc_word_t     result;
  sadc_word_t     next_result;
  logic           next_busy_n;
  logic           sar_done;
  sadc_word_t     sar_word;
  logic           sar_start;
  logic           next_done_q;

  assign conv_active = (state != SADC_IDLE);
  assign sar_start   = start_pulse;

  always_comb begin
    next_state  = state;
    next_sample = sample_q;
    next_result = result;
    next_busy_n = busy_n;
    // High in the first idle cycle after busy rises
    next_done_q = (state == SADC_DONE);
    case (state)
      SADC_IDLE: begin
        if (start_pulse) begin
          next_sample = analog_sample;
          next_busy_n = 1'b0;
          next_state  = SADC_CONV;
        end
      end
      SADC_CONV: begin
        // Further starts are not looked at here
        if (sar_done) begin
          // Engine works offset binary; sign bit flipped back
          next_result = sar_word ^ 16'h8000;
          next_state  = SADC_DONE;
        end
      end
      SADC_DONE: begin
        // Busy rises one cycle after the latch so data is settled
        next_busy_n = 1'b1;
        next_state  = SADC_IDLE;
      end
      default: begin
        next_state  = SADC_IDLE;
        next_busy_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state    <= SADC_IDLE;
      sample_q <= `SADC_RESULT_RST;
      result   <= `SADC_RESULT_RST;
      busy_n   <= 1'b1;
      done_q   <= 1'b0;
    end else begin
      state    <= next_state;
      sample_q <= next_sample;
      result   <= next_result;
      busy_n   <= next_busy_n;
      done_q   <= next_done_q;
    end
  end

  assign hold = conv_active;

  sadc_sar #(
    .W        (W),
    .STEP_CYC (STEP_CYC)
  ) u_sar (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (sar_start),
    .sample (sample_q),
    .done   (sar_done),
    .sar    (sar_word)
  );

  // ****************************************
  // Output port
  // ****************************************
  logic [7:0] next_upper;
  logic [7:0] next_lower;
  logic       next_oe;

  always_comb begin
    // Result held raw: two's complement, zero wraps from all ones
    if (byte_s) begin
      next_upper = result[7:0];
      next_lower = result[15:8];
    end else begin
      next_upper = result[15:8];
      next_lower = result[7:0];
    end
    // Drive only with select low and read/convert high
    next_oe = !cs_s && rc_s;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      upper_data_lines <= 8'h00;
      lower_data_lines <= 8'h00;
      data_oe          <= 1'b0;
    end else begin
      upper_data_lines <= next_upper;
      lower_data_lines <= next_lower;
      data_oe          <= next_oe;
    end
  end

  // ****************************************
  // Conversion length helper
  // ****************************************
  // A counter keeps the length check free of a long delay range
  localparam int CONV_LEN = W * STEP_CYC;
  localparam int CCW      = $clog2(CONV_LEN + 2);

  logic [CCW-1:0] conv_cnt;
  logic [CCW-1:0] next_conv_cnt;

  always_comb begin
    next_conv_cnt = '0;
    // Counts to one past the limit, then restarts from zero; a hang trips the bound check each lap
    if ((state == SADC_CONV) && (conv_cnt <= CCW'(CONV_LEN))) begin
      next_conv_cnt = conv_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt <= '0;
    end else begin
      conv_cnt <= next_conv_cnt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_busy_start;
    @(posedge clock) disable iff (!rst_n)
      start_pulse |=> !busy_n;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not low after start");

  property p_no_restart;
    @(posedge clock) disable iff (!rst_n)
      (state == SADC_CONV) && !sar_done |=> (state == SADC_CONV) && $stable(sample_q);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion restarted");

  property p_busy_low_conv;
    @(posedge clock) disable iff (!rst_n)
      (state == SADC_CONV) |-> !busy_n;
  endproperty
  a_busy_low_conv: assert property (p_busy_low_conv) else $error("busy high during conversion");

  property p_result_at_busy;
    @(posedge clock) disable iff (!rst_n)
      $rose(busy_n) |-> $stable(result) && $past(sar_done, 2);
  endproperty
  a_result_at_busy: assert property (p_result_at_busy) else $error("busy rose before result");

  property p_hiz_rc_low;
    @(posedge clock) disable iff (!rst_n)
      !rc_s |=> !data_oe;
  endproperty
  a_hiz_rc_low: assert property (p_hiz_rc_low) else $error("data driven with read/convert low");

  property p_read_enable;
    @(posedge clock) disable iff (!rst_n)
      (!cs_s && rc_s) |=> data_oe;
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("read not enabled");

  property p_byte_order;
    @(posedge clock) disable iff (!rst_n)
      !byte_s |=> upper_data_lines == $past(result[15:8]) && lower_data_lines == $past(result[7:0]);
  endproperty
  a_byte_order: assert property (p_byte_order) else $error("word order wrong");

  property p_byte_swap;
    @(posedge clock) disable iff (!rst_n)
      byte_s |=> upper_data_lines == $past(result[7:0]) && lower_data_lines == $past(result[15:8]);
  endproperty
  a_byte_swap: assert property (p_byte_swap) else $error("byte swap wrong");

  property p_conv_length;
    @(posedge clock) disable iff (!rst_n)
      (state == SADC_CONV) && sar_done |-> conv_cnt == CCW'(CONV_LEN);
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");

  property p_conv_bound;
    @(posedge clock) disable iff (!rst_n)
      (state == SADC_CONV) |-> conv_cnt <= CCW'(CONV_LEN);
  endproperty
  a_conv_bound: assert property (p_conv_bound) else $error("conversion did not finish");

  property p_hold_start;
    @(posedge clock) disable iff (!rst_n)
      start_pulse |=> hold;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("sample not held at start");

  property p_sar_clear;
    @(posedge clock) disable iff (!rst_n)
      sar_start |=> sar_word == 16'h0000;
  endproperty
  a_sar_clear: assert property (p_sar_clear) else $error("approximation register not cleared");

endmodule : sadc_core
`default_nettype wire

// ==== design/sadc_params.svh ====
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define SADC_CLK_NS         40
`define SADC_CONV_NS        7000
`define SADC_START_MIN_NS   40
// Least time rounds up
`define SADC_START_CYC      ((`SADC_START_MIN_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
// Conversion time in whole clock cycles, rounded down
`define SADC_CONV_CYC       (`SADC_CONV_NS / `SADC_CLK_NS)

// ****************************************
// Data layout
// ****************************************
`define SADC_WIDTH          16
`define SADC_BYTE_W         8
`define SADC_RESULT_RST     16'h0000

`endif

// ==== design/sadc_pkg.sv ====
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_CONV,
    SADC_DONE
  } sadc_state_e;
  typedef logic [15:0] sadc_word_t;
endpackage : sadc_pkg

// ==== design/sadc_sar.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sadc_params.svh"
// ****************************************
// Successive approximation engine
// ****************************************
module sadc_sar #(
  parameter int W        = `SADC_WIDTH,
  parameter int STEP_CYC = `SADC_CONV_CYC / `SADC_WIDTH
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] sample,
  output logic              done,
  output logic      [W-1:0] sar
);
  localparam int CW = $clog2(STEP_CYC + 1);
  localparam int BW = $clog2(W);

  logic          active;
  logic [CW-1:0] step_cnt;
  logic [BW-1:0] bit_idx;
  logic          next_active;
  logic          next_done;
  logic [CW-1:0] next_step_cnt;
  logic [BW-1:0] next_bit_idx;
  logic [W-1:0]  next_sar;
  logic [W-1:0]  trial;

  always_comb begin
    next_active   = active;
    next_done     = 1'b0;
    next_step_cnt = step_cnt;
    next_bit_idx  = bit_idx;
    next_sar      = sar;
    trial         = sar;
    if (start && !active) begin
      next_active   = 1'b1;
      next_sar      = '0;
      next_bit_idx  = BW'(W - 1);
      next_step_cnt = CW'(STEP_CYC - 1);
    end else if (active) begin
      if (step_cnt != '0) begin
        next_step_cnt = step_cnt - 1'b1;
      end else begin
        // Offset binary trial against a two's complement sample
        trial          = sar;
        trial[bit_idx] = 1'b1;
        next_sar[bit_idx] = (trial <= (sample ^ {1'b1, {(W-1){1'b0}}}));
        next_step_cnt  = CW'(STEP_CYC - 1);
        if (bit_idx == '0) begin
          next_active = 1'b0;
          next_done   = 1'b1;
        end else begin
          next_bit_idx = bit_idx - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active   <= 1'b0;
      done     <= 1'b0;
      step_cnt <= '0;
      bit_idx  <= '0;
      sar      <= '0;
    end else begin
      active   <= next_active;
      done     <= next_done;
      step_cnt <= next_step_cnt;
      bit_idx  <= next_bit_idx;
      sar      <= next_sar;
    end
  end
endmodule : sadc_sar
`default_nettype wire

// ==== design/sadc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module sadc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule : sadc_sync
`default_nettype wire

// ==== verification/sadc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side of the parallel port
// ****************************************
module sadc_host_model (
  input  wire logic       clock,
  input  wire logic       busy_n,
  input  wire logic [7:0] upper_data_lines,
  input  wire logic [7:0] lower_data_lines,
  input  wire logic       data_oe,
  output var  logic       select_n,
  output var  logic       read_conv,
  output var  logic       byte_swap
);
  import sadc_pkg::*;
  sadc_word_t last_word = 16'h0000;
  sadc_word_t data_bus;
  // Released lines show the inverse, so a stale copy never passes
  assign data_bus = data_oe ? {upper_data_lines, lower_data_lines} : ~last_word;
  always @(posedge clock) begin
    if (data_oe === 1'b1) begin
      last_word <= data_bus;
    end
  end
  initial begin
    select_n  = 1'b1;
    read_conv = 1'b1;
    byte_swap = 1'b0;
  end
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask : cycles
  // Every task starts on a fresh edge: no line driven twice in one step
  task automatic drive_start(input logic use_cs);
    @(posedge clock);
    select_n  <= use_cs;
    read_conv <= 1'b0;
    if (use_cs) begin
      @(posedge clock);
      select_n <= 1'b0;
    end
  endtask : drive_start
  task automatic release_start(input logic use_cs);
    @(posedge clock);
    read_conv <= 1'b1;
    select_n  <= use_cs;
  endtask : release_start
  task automatic read_word(input logic swap, input logic use_cs, output sadc_word_t word);
    int n;
    @(posedge clock);
    byte_swap <= swap;
    read_conv <= 1'b1;
    select_n  <= 1'b0;
    n = 0;
    @(posedge clock);
    while (data_oe !== 1'b1 && n < 10) begin
      @(posedge clock);
      n++;
    end
    // Byte select lags through the synchroniser it shares with select and read/convert
    cycles(3);
    word = data_bus;
    if (use_cs) begin
      select_n <= 1'b1;
    end
  endtask : read_word
endmodule : sadc_host_model
`default_nettype wire

// ==== verification/tb_sar_adc_parallel_readout.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_parallel_readout;
  import sadc_pkg::*;
  // Short bit steps keep the run brief
  localparam int STEP     = 2;
  localparam int CONV_CYC = 16 * STEP;
  logic       clock;
  logic       rst_n;
  sadc_word_t analog_sample;
  wire logic  select_n, read_conv, byte_swap, busy_n, hold, data_oe;
  wire logic [7:0] upper_data_lines, lower_data_lines;
  int n_mismatch = 0;
  int checked    = 0;
  int low_cnt    = 0;
  sadc_word_t codes[5] = '{16'hFFFF, 16'h0000, 16'h7FFF, 16'h8000, 16'h1234};

  sadc_core #(.STEP_CYC(STEP)) u_dut (
    .clock(clock), .rst_n(rst_n), .select_n(select_n), .read_conv(read_conv),
    .byte_swap(byte_swap), .analog_sample(analog_sample), .busy_n(busy_n), .hold(hold),
    .upper_data_lines(upper_data_lines), .lower_data_lines(lower_data_lines), .data_oe(data_oe));
  sadc_host_model u_host (
    .clock(clock), .busy_n(busy_n), .upper_data_lines(upper_data_lines),
    .lower_data_lines(lower_data_lines), .data_oe(data_oe), .select_n(select_n),
    .read_conv(read_conv), .byte_swap(byte_swap));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (busy_n === 1'b0) begin
      low_cnt++;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic bit cmp(input sadc_word_t got, input sadc_word_t exp);
    checked++;
    return got !== exp;
  endfunction : cmp
  task automatic fail(input string msg);
    n_mismatch++;
    $display("ERROR %0t %s", $time, msg);
  endtask : fail
  // One conversion; repulse tries a second start mid-conversion
  task automatic convert(input logic use_cs, input sadc_word_t smp, input logic repulse);
    int n;
    analog_sample <= smp;
    low_cnt = 0;
    u_host.drive_start(use_cs);
    u_host.cycles(5);
    if (cmp(data_oe, 1'b0)) fail("lines driven while convert low");
    if (cmp(hold, 1'b1)) fail("sample not held");
    if (cmp(busy_n, 1'b0)) fail("busy not low at start");
    u_host.release_start(use_cs);
    analog_sample <= ~smp;
    if (repulse) begin
      u_host.cycles(3);
      u_host.drive_start(use_cs);
      repeat (5) begin
        @(posedge clock);
        if (cmp(busy_n, 1'b0)) fail("busy left low state on restart");
      end
      u_host.release_start(use_cs);
    end
    n = 0;
    while (busy_n !== 1'b1 && n < CONV_CYC + 40) begin
      @(posedge clock);
      n++;
    end
    if (cmp(busy_n, 1'b1)) fail("busy never rose");
    if (low_cnt < CONV_CYC || low_cnt > CONV_CYC + 6) fail("conversion length wrong");
    checked++;
  endtask : convert
  task automatic read_check(input logic swap, input logic use_cs, input sadc_word_t smp);
    sadc_word_t got;
    u_host.read_word(swap, use_cs, got);
    if (cmp(got, swap ? {smp[7:0], smp[15:8]} : smp)) fail("result word wrong");
    u_host.cycles(25);
  endtask : read_check

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_rc_codes();
    foreach (codes[i]) begin
      convert(1'b0, codes[i], 1'b0);
      read_check(1'b0, 1'b0, codes[i]);
    end
    $display("t_rc_codes done");
  endtask : t_rc_codes
  task automatic t_cs_swap();
    convert(1'b1, 16'hA55C, 1'b0);
    read_check(1'b0, 1'b1, 16'hA55C);
    read_check(1'b1, 1'b1, 16'hA55C);
    $display("t_cs_swap done");
  endtask : t_cs_swap
  task automatic t_no_restart();
    convert(1'b0, 16'h4C31, 1'b1);
    read_check(1'b1, 1'b0, 16'h4C31);
    $display("t_no_restart done");
  endtask : t_no_restart

  task automatic tally_and_finish();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5000) @(posedge clock);
    fail("watchdog expired");
    tally_and_finish();
  end
  initial begin
    rst_n         = 1'b0;
    analog_sample = 16'h0000;
    repeat (8) @(posedge clock);
    if (cmp(busy_n, 1'b1)) fail("busy low in reset");
    if (cmp(data_oe, 1'b0)) fail("lines driven in reset");
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    u_host.cycles(4);
    t_rc_codes();
    t_cs_swap();
    t_no_restart();
    tally_and_finish();
  end
endmodule : tb_sar_adc_parallel_readout
`default_nettype wire
